// ==== core/vbl_pkg.sv ====
// Constants shared by the video subsystem buffer logic block
package vbl_pkg;

   // Block base addresses in the subsystem map
   localparam logic [31:0] BUFFER_LOGIC_BASE  = 32'h01C7_0800;
   localparam logic [31:0] CLOCK_GATING_BASE  = 32'h01C7_0000;
   // Address bits at and above this position select a block
   localparam int          BLOCK_SPAN_BITS    = 7;

   // Gated clock domains: sensor controller, image pipe, statistics
   localparam int          CLK_SENSOR         = 0;
   localparam int          CLK_PIPE           = 1;
   localparam int          CLK_STATS          = 2;
   localparam int          NUM_GATED_CLOCKS   = 3;

   // Read buffer steering: bit that hands read data to statistics
   localparam int          RD_TO_STATS_BIT    = 0;

   // Default sizes
   localparam int          PATH_CTRL_W        = 2;
   localparam int          DATA_W             = 32;
   localparam int          NUM_SOURCES        = 8;
   localparam int          NUM_ROUTES         = 4;

   // Reset values of every held setting
   localparam logic [NUM_GATED_CLOCKS-1:0] CLK_EN_RST = 3'h0;
   localparam logic [PATH_CTRL_W-1:0]      PATH_RST   = 2'h0;
   localparam logic                        BIT_RST    = 1'h0;

endpackage

// ==== core/vbl_clock_gate.sv ====
// Glitch-free clock gate for one sub-module clock
`timescale 1ns/1ps

module vbl_clock_gate (
   input  wire logic clk_i,     // Free-running subsystem clock
   input  wire logic rst_i,     // Synchronous reset, active high
   input  wire logic en_i,      // Gate enable, registered upstream
   output logic      gclk_o     // Gated clock to the sub-module
);

   logic en_lat_ff;             // Enable held while the clock is low
   logic nxt_en_lat;            // Next enable

   ////////////////////////////////////////////////////////////////////////
   // Enable sampling

   // Next enable, forced off under reset
   always_comb begin
      nxt_en_lat = rst_i ? 1'h0 : en_i;
   end

   // Taken on the falling edge so the gate only opens or closes while
   // the clock is low; a high phase is never cut short
   always_ff @(negedge clk_i) begin
      en_lat_ff <= nxt_en_lat;
   end

   // Clock passes only while the held enable is set
   assign gclk_o = clk_i & en_lat_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   // A steady enable reaches the gate by the next rising edge
   a_gate_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      en_i ##1 en_i |-> en_lat_ff)
      else $error("gate enable not applied");

   // A withdrawn enable closes the gate within one cycle
   a_gate_closes: assert property (@(posedge clk_i) disable iff (rst_i)
      !en_i ##1 !en_i |-> !en_lat_ff)
      else $error("gate enable not removed");

endmodule // vbl_clock_gate

// ==== core/vbl_buffer_logic.sv ====
// Video subsystem buffer logic: paths, event routing, clock gating
//
// Behaviour
// - Switch data paths, route interrupts, gate clocks
// - Subsystem reset returns every setting to default
// - Settings act at once, no shadowing
// - Interrupt route select picks processor interrupts
// - Separate route select picks DMA events
// - Pollable interrupt status, independent of routing
// - Decode buffer logic and clock blocks
`timescale 1ns/1ps

module vbl_buffer_logic #(
   parameter int PATH_W  = vbl_pkg::PATH_CTRL_W,  // Path control width
   parameter int DW      = vbl_pkg::DATA_W,       // Buffer data width
   parameter int NSRC    = vbl_pkg::NUM_SOURCES,  // Event sources
   parameter int NOUT    = vbl_pkg::NUM_ROUTES,   // Routed lines
   parameter int SELW    = $clog2(NSRC)           // Route select width
) (
   input  wire logic                  clock_i,
   input  wire logic                  rst_i,
   // Block decode
   input  wire logic [31:0]           addr_i,
   output logic                       bl_sel_o,
   output logic                       clk_sel_o,
   // Clock gating
   input  wire logic [vbl_pkg::NUM_GATED_CLOCKS-1:0] clk_enable_i,
   output logic [vbl_pkg::NUM_GATED_CLOCKS-1:0]      clk_enable_o,
   output logic [vbl_pkg::NUM_GATED_CLOCKS-1:0]      gated_clk_o,
   // Buffer path controls
   input  wire logic [PATH_W-1:0]     read_buffer_control_i,
   input  wire logic [PATH_W-1:0]     write_buffer_control_i,
   input  wire logic                  pipe_write_enable_i,
   input  wire logic [PATH_W-1:0]     resizer_path_control_i,
   input  wire logic [PATH_W-1:0]     defect_memory_control_i,
   output logic [PATH_W-1:0]          read_buffer_control_o,
   output logic [PATH_W-1:0]          write_buffer_control_o,
   output logic                       pipe_write_enable_o,
   output logic [PATH_W-1:0]          resizer_path_control_o,
   output logic [PATH_W-1:0]          defect_memory_control_o,
   // Read data from the buffer, steered to one reader
   input  wire logic [DW-1:0]         rd_data_i,
   input  wire logic                  rd_valid_i,
   output logic [DW-1:0]              rd_data_o,
   output logic                       pif_rd_valid_o,
   output logic                       stats_rd_valid_o,
   // Image pipe write data into the buffer
   input  wire logic [DW-1:0]         wr_data_i,
   input  wire logic                  wr_valid_i,
   output logic [DW-1:0]              buf_wr_data_o,
   output logic                       buf_wr_valid_o,
   // Sub-module events and their routing
   input  wire logic [NSRC-1:0]       evt_i,
   input  wire logic [NOUT*SELW-1:0]  interrupt_route_select_i,
   input  wire logic [NOUT*SELW-1:0]  dma_event_route_select_i,
   input  wire logic [NSRC-1:0]       status_clr_i,
   output logic [NOUT-1:0]            irq_o,
   output logic [NOUT-1:0]            dma_evt_o,
   output logic [NSRC-1:0]            interrupt_poll_status_o
);

   ////////////////////////////////////////////////////////////////////////
   // Held settings

   logic [vbl_pkg::NUM_GATED_CLOCKS-1:0] clk_en_ff;   // Clock enables
   logic [vbl_pkg::NUM_GATED_CLOCKS-1:0] nxt_clk_en;
   logic [PATH_W-1:0] rbuf_ff, wbuf_ff, resz_ff, dfc_ff; // Path controls
   logic [PATH_W-1:0] nxt_rbuf, nxt_wbuf, nxt_resz, nxt_dfc;
   logic              pwen_ff;                       // Pipe write enable
   logic              nxt_pwen;

   // Settings follow their inputs every cycle, no frame latching
   always_comb begin
      nxt_clk_en = clk_enable_i;
      nxt_rbuf   = read_buffer_control_i;
      nxt_wbuf   = write_buffer_control_i;
      nxt_resz   = resizer_path_control_i;
      nxt_dfc    = defect_memory_control_i;
      nxt_pwen   = pipe_write_enable_i;
      if (rst_i) begin
         nxt_clk_en = vbl_pkg::CLK_EN_RST;
         nxt_rbuf   = vbl_pkg::PATH_RST;
         nxt_wbuf   = vbl_pkg::PATH_RST;
         nxt_resz   = vbl_pkg::PATH_RST;
         nxt_dfc    = vbl_pkg::PATH_RST;
         nxt_pwen   = vbl_pkg::BIT_RST;
      end
   end

   // Settings registers
   always_ff @(posedge clock_i) begin
      clk_en_ff <= nxt_clk_en;
      rbuf_ff   <= nxt_rbuf;
      wbuf_ff   <= nxt_wbuf;
      resz_ff   <= nxt_resz;
      dfc_ff    <= nxt_dfc;
      pwen_ff   <= nxt_pwen;
   end

   assign clk_enable_o            = clk_en_ff;
   assign read_buffer_control_o   = rbuf_ff;
   assign write_buffer_control_o  = wbuf_ff;
   assign resizer_path_control_o  = resz_ff;
   assign defect_memory_control_o = dfc_ff;
   assign pipe_write_enable_o     = pwen_ff;

   ////////////////////////////////////////////////////////////////////////
   // Clock gates, one per sub-module clock; the pipe interface shares
   // the image pipe clock, so only three gates exist

   for (genvar g = 0; g < vbl_pkg::NUM_GATED_CLOCKS; g++) begin : g_gate
      vbl_clock_gate u_gate (
         .clk_i  (clock_i),
         .rst_i  (rst_i),
         .en_i   (clk_en_ff[g]),
         .gclk_o (gated_clk_o[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Block decode

   logic bl_sel_ff, clk_sel_ff;                // Registered selects
   logic nxt_bl_sel, nxt_clk_sel;

   // Compare only the bits above the block span
   always_comb begin
      nxt_bl_sel  = !rst_i && (addr_i[31:vbl_pkg::BLOCK_SPAN_BITS] ==
         vbl_pkg::BUFFER_LOGIC_BASE[31:vbl_pkg::BLOCK_SPAN_BITS]);
      nxt_clk_sel = !rst_i && (addr_i[31:vbl_pkg::BLOCK_SPAN_BITS] ==
         vbl_pkg::CLOCK_GATING_BASE[31:vbl_pkg::BLOCK_SPAN_BITS]);
   end

   always_ff @(posedge clock_i) begin
      bl_sel_ff  <= nxt_bl_sel;
      clk_sel_ff <= nxt_clk_sel;
   end

   assign bl_sel_o  = bl_sel_ff;
   assign clk_sel_o = clk_sel_ff;

   ////////////////////////////////////////////////////////////////////////
   // Data path switches

   logic [DW-1:0] rd_data_ff, wr_data_ff;      // Steered data
   logic [DW-1:0] nxt_rd_data, nxt_wr_data;
   logic          pif_v_ff, stats_v_ff, wr_v_ff; // Steered valids
   logic          nxt_pif_v, nxt_stats_v, nxt_wr_v;

   // Read data goes to exactly one reader; writes pass only when the
   // image pipe write enable is on. Switching mid-frame splits a frame
   // between readers, which is why software quiesces first.
   always_comb begin
      nxt_rd_data = rd_data_i;
      nxt_wr_data = wr_data_i;
      nxt_stats_v = rd_valid_i && rbuf_ff[vbl_pkg::RD_TO_STATS_BIT];
      nxt_pif_v   = rd_valid_i && !rbuf_ff[vbl_pkg::RD_TO_STATS_BIT];
      nxt_wr_v    = wr_valid_i && pwen_ff;
      if (rst_i) begin
         nxt_rd_data = '0;
         nxt_wr_data = '0;
         nxt_stats_v = 1'h0;
         nxt_pif_v   = 1'h0;
         nxt_wr_v    = 1'h0;
      end
   end

   always_ff @(posedge clock_i) begin
      rd_data_ff <= nxt_rd_data;
      wr_data_ff <= nxt_wr_data;
      pif_v_ff   <= nxt_pif_v;
      stats_v_ff <= nxt_stats_v;
      wr_v_ff    <= nxt_wr_v;
   end

   assign rd_data_o        = rd_data_ff;
   assign pif_rd_valid_o   = pif_v_ff;
   assign stats_rd_valid_o = stats_v_ff;
   assign buf_wr_data_o    = wr_data_ff;
   assign buf_wr_valid_o   = wr_v_ff;

   ////////////////////////////////////////////////////////////////////////
   // Event routing and poll status

   logic [NOUT-1:0] irq_ff, dma_ff;            // Routed lines
   logic [NOUT-1:0] nxt_irq, nxt_dma;
   logic [NSRC-1:0] stat_ff;                   // Sticky poll status
   logic [NSRC-1:0] nxt_stat;

   // Each routed line copies the source its select names; the two
   // selects are independent, so one source may feed both or either
   always_comb begin
      for (int k = 0; k < NOUT; k++) begin
         nxt_irq[k] = evt_i[interrupt_route_select_i[k*SELW +: SELW]];
         nxt_dma[k] = evt_i[dma_event_route_select_i[k*SELW +: SELW]];
      end
      // A new event beats a clear in the same cycle
      nxt_stat = (stat_ff & ~status_clr_i) | evt_i;
      if (rst_i) begin
         nxt_irq  = '0;
         nxt_dma  = '0;
         nxt_stat = '0;
      end
   end

   always_ff @(posedge clock_i) begin
      irq_ff  <= nxt_irq;
      dma_ff  <= nxt_dma;
      stat_ff <= nxt_stat;
   end

   assign irq_o                   = irq_ff;
   assign dma_evt_o               = dma_ff;
   assign interrupt_poll_status_o = stat_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   wire [SELW-1:0] isel0 = interrupt_route_select_i[SELW-1:0];
   wire [SELW-1:0] dsel0 = dma_event_route_select_i[SELW-1:0];

   sequence s_clk_write;
      $changed(clk_enable_i);
   endsequence

   sequence s_clk_applied;
      clk_enable_o == $past(clk_enable_i);
   endsequence

   a_reset_values: assert property (@(posedge clock_i) disable iff (rst_i)
      $fell(rst_i) |-> clk_enable_o == '0 && interrupt_poll_status_o == '0
         && read_buffer_control_o == '0 && irq_o == '0 && dma_evt_o == '0)
      else $error("setting not at reset value");

   a_setting_immediate: assert property (@(posedge clock_i)
      disable iff (rst_i) s_clk_write |=> s_clk_applied)
      else $error("clock enable change delayed");

   a_irq_route: assert property (@(posedge clock_i) disable iff (rst_i)
      evt_i[isel0] |=> irq_o[0])
      else $error("selected interrupt not routed");

   a_irq_blocked: assert property (@(posedge clock_i) disable iff (rst_i)
      !evt_i[isel0] |=> !irq_o[0])
      else $error("unselected interrupt routed");

   a_dma_route: assert property (@(posedge clock_i) disable iff (rst_i)
      evt_i[dsel0] ##1 1'b1 |-> dma_evt_o[0] == 1'b1)
      else $error("selected dma event not routed");

   a_status_set_wins: assert property (@(posedge clock_i)
      disable iff (rst_i) evt_i != '0 |=>
      (interrupt_poll_status_o & $past(evt_i)) == $past(evt_i))
      else $error("event lost in poll status");

   a_status_clear: assert property (@(posedge clock_i) disable iff (rst_i)
      status_clr_i[0] && !evt_i[0] |=> !interrupt_poll_status_o[0])
      else $error("poll status bit not cleared");

   a_path_switch: assert property (@(posedge clock_i) disable iff (rst_i)
      rd_valid_i && read_buffer_control_o[vbl_pkg::RD_TO_STATS_BIT]
      |=> stats_rd_valid_o && !pif_rd_valid_o)
      else $error("read data not steered to statistics");

   a_block_decode: assert property (@(posedge clock_i) disable iff (rst_i)
      addr_i == vbl_pkg::BUFFER_LOGIC_BASE |=> bl_sel_o && !clk_sel_o)
      else $error("buffer logic base not decoded");

endmodule // vbl_buffer_logic

// ==== verification/vbl_partner_model.sv ====
// Sub-module side model: clocked event sources and gated clock counters
`timescale 1ns/1ps

module vbl_partner_model (
   input  wire logic       clock_i,    // Subsystem clock
   input  wire logic [2:0] gclk_i,     // Gated clocks from the block
   input  wire logic [7:0] fire_i,     // Bench asks a source to signal
   output logic      [7:0] evt_o,      // Event lines into the block
   output int              cnt_o [3]   // Clock edges seen per module
);
   ////////////////////////////////////////////////////////////////////////
   // Events leave the sub-modules registered, as real logic would
   always_ff @(posedge clock_i) begin
      evt_o <= fire_i;
   end
   // Each module only advances on its own gated clock, never the free one
   for (genvar k = 0; k < 3; k++) begin : g_cnt
      initial cnt_o[k] = 0;
      always @(posedge gclk_i[k]) cnt_o[k]++;
   end
endmodule // vbl_partner_model

// ==== verification/testbench.sv ====
// Self-checking bench for the video subsystem buffer logic
`timescale 1ns/1ps

module testbench;
   logic        clock_i = 1'b0;  // 10 MHz clock
   logic        rst_i   = 1'b1;  // Synchronous reset
   logic [31:0] addr_i  = 32'h0; // Decoded address
   logic [2:0]  cke_i   = 3'h7;  // Clock enables, set during reset
   logic [1:0]  rb = 2'h3, wb = 2'h3, rz = 2'h3, df = 2'h3; // Paths
   logic        we = 1'h1, rv = 1'h0, wv = 1'h0; // Write enable, valids
   logic [31:0] rd = 32'h0, wd = 32'h0; // Buffer data words
   logic [11:0] isel = 12'h0, dsel = 12'h0; // Route selects
   logic [7:0]  fire = 8'h0, clr = 8'h0, evt; // Events and clears
   logic        bl_sel, ck_sel, pv, sv, bwv, pwe;
   logic [2:0]  cke_o, gclk;
   logic [1:0]  rb_o, wb_o, rz_o, df_o;
   logic [31:0] rd_o, bwd;
   logic [3:0]  irq, dma;
   logic [7:0]  stat;
   int          cnt [3];
   int          n_fail = 0, n_tests = 0;

   vbl_buffer_logic i_vbl_buffer_logic (.clock_i(clock_i), .rst_i(rst_i),
      .addr_i(addr_i), .bl_sel_o(bl_sel), .clk_sel_o(ck_sel),
      .clk_enable_i(cke_i), .clk_enable_o(cke_o), .gated_clk_o(gclk),
      .read_buffer_control_i(rb), .write_buffer_control_i(wb),
      .pipe_write_enable_i(we), .resizer_path_control_i(rz),
      .defect_memory_control_i(df), .read_buffer_control_o(rb_o),
      .write_buffer_control_o(wb_o), .pipe_write_enable_o(pwe),
      .resizer_path_control_o(rz_o), .defect_memory_control_o(df_o),
      .rd_data_i(rd), .rd_valid_i(rv), .rd_data_o(rd_o),
      .pif_rd_valid_o(pv), .stats_rd_valid_o(sv), .wr_data_i(wd),
      .wr_valid_i(wv), .buf_wr_data_o(bwd), .buf_wr_valid_o(bwv),
      .evt_i(evt), .interrupt_route_select_i(isel),
      .dma_event_route_select_i(dsel), .status_clr_i(clr), .irq_o(irq),
      .dma_evt_o(dma), .interrupt_poll_status_o(stat));
   vbl_partner_model i_vbl_partner_model (.clock_i(clock_i),
      .gclk_i(gclk), .fire_i(fire), .evt_o(evt), .cnt_o(cnt));

   ////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and shared helpers
   initial begin
      forever #50 clock_i = ~clock_i;
   end
   initial begin
      #300000;
      n_fail++;
      end_sim();
   end
   // Wait n edges, then step past them so registered outputs have landed
   task automatic cyc(int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // Wide enough for a data word packed with its steering flags
   task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("bench passed");
      end
      else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   // Reset overrides live inputs; gated clocks stay quiet
   // Two edges see reset; the gate latch closed at the falling edge between
   task automatic t_reset();
      @(posedge clock_i);
      @(posedge clock_i) rst_i <= 1'b0;
      #1;
      chk("rst_paths", {cke_o, rb_o, wb_o, rz_o, df_o, pwe}, 32'h0);
      chk("rst_gclk", {gclk, irq, dma, stat}, 32'h0);
      cyc(1);
      chk("post_rst", {cke_o, rb_o, wb_o, rz_o, df_o, pwe}, 12'hFFF);
   endtask
   // Only enabled domains tick, exactly once per subsystem cycle
   task automatic t_gate(logic [2:0] en);
      int c [3];
      @(posedge clock_i) cke_i <= en;
      cyc(3);
      c = cnt;
      cyc(8);
      for (int k = 0; k < 3; k++)
         chk("gclk_edges", cnt[k] - c[k], en[k] ? 8 : 0);
   endtask
   // Read steering and write gating, word for word, back to back
   // Clocks and paths are set while traffic is idle, one cycle ahead,
   // because the steering acts on the held copy of the controls
   task automatic t_paths(logic st, logic wen);
      @(posedge clock_i) {cke_i, rb, we} <= {3'h7, 1'b0, st, wen};
      @(posedge clock_i) {rv, wv, rd, wd} <=
         {2'h3, 32'hA5A5_0001, 32'h5A5A_0002};
      @(posedge clock_i) rd <= 32'hA5A5_0003;
      #1;
      chk("rd_first", {rd_o, pv, sv}, {32'hA5A5_0001, !st, st});
      chk("wr_valid", {bwv, pwe}, {wen, wen});
      @(posedge clock_i) {rv, wv} <= 2'h0;
      #1;
      chk("rd_second", rd_o, 32'hA5A5_0003);
      if (wen) chk("wr_data", bwd, 32'h5A5A_0002);
      cyc(1);
      chk("rd_idle", {pv, sv, bwv}, 3'h0);
   endtask
   // Every source through every interrupt line; events routed apart
   task automatic t_route();
      for (int s = 0; s < 8; s++) begin
         @(posedge clock_i) fire <= 8'h1 << s;
         isel <= {4{3'(s)}};
         dsel <= {3'h7, 3'h7, 3'h5, 3'h7};
         cyc(2);
         chk("irq", irq, 4'hF);
         chk("dma", dma, s == 5 ? 4'h2 : (s == 7 ? 4'hD : 4'h0));
      end
      @(posedge clock_i) fire <= 8'h0;
      cyc(2);
   endtask
   // Sticky poll flags: set wins over a clear in the same cycle
   task automatic t_status();
      @(posedge clock_i) clr <= 8'hFF;
      @(posedge clock_i) {clr, fire} <= 16'h0004;
      @(posedge clock_i) fire <= 8'h0;
      cyc(2);
      chk("stat_set", stat, 8'h04);
      @(posedge clock_i) {clr, fire} <= 16'h0404;
      @(posedge clock_i) fire <= 8'h0;
      cyc(1);
      chk("stat_win", stat, 8'h04);
      cyc(1);
      chk("stat_clr", stat, 8'h00);
      @(posedge clock_i) clr <= 8'h0;
   endtask
   // Block decode at the edges of each span and at a foreign block
   task automatic t_decode();
      logic [31:0] a [5] = '{32'h01C7_0800, 32'h01C7_087F, 32'h01C7_0000,
                             32'h01C7_0080, 32'h01C7_0600};
      logic [1:0]  e [5] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h0};
      for (int i = 0; i < 5; i++) begin
         @(posedge clock_i) addr_i <= a[i];
         cyc(1);
         chk("decode", {bl_sel, ck_sel}, e[i]);
      end
   endtask

   initial begin
      t_reset();
      t_gate(3'h2);
      t_gate(3'h5);
      t_gate(3'h0);
      t_paths(1'b1, 1'b1);
      t_paths(1'b0, 1'b0);
      t_route();
      t_status();
      t_decode();
      end_sim();
   end
endmodule // testbench
